// ### rtl/tsr_pkg.sv
// shared constants and types for the tdm stream rate and frame timing block
// Operation
// - master clock shifts every stream bit
// - frame pulse low width by mode
// - bus clock only aligns CT/HMVIP frames
// - local frame pulse 244 ns low
// - local clock 4.096 MHz from master
// - backplane 0-15: 2/4/8 Mb/s rates
// - backplane 16-23: 2/4 Mb/s, HMVIP 8
// - backplane 24-31 only 2/4 Mb/s
// - eval mode makes 0-23 evaluation inputs
// - local 0-3: 2 or 8 Mb/s
// - local 4-11: 2 Mb/s only
// - reset clears counters and registers
// - sub-rate switches 2-bit 16 kb/s channels
// - 512 local output channels capacity
// - frame pulse every 125 us
// - 8 Mb/s backplane uses streams 0-15
// - sub-rate: stream 12 carries 128 channels
// - drive gate low disables all stream outputs
package tsr_pkg;
   // master clock and frame geometry
   localparam int MCLK_KHZ = 16384; // master clock rate
   localparam int FRAME_US = 125; // frame period
   localparam int FRAME_MCYC = MCLK_KHZ * FRAME_US / 1000; // master cycles per frame
   localparam int CNT_W = $clog2(FRAME_MCYC); // frame counter width
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_MCYC - 1);
   // frame pulse widths, least times rounded up to master cycles
   localparam int FP_NATIVE_NS = 61;
   localparam int FP_CT_NS = 122;
   localparam int FP_HMVIP_NS = 244;
   localparam int FP_NATIVE_MCYC = (FP_NATIVE_NS * MCLK_KHZ + 999999) / 1000000;
   localparam int FP_CT_MCYC = (FP_CT_NS * MCLK_KHZ + 999999) / 1000000;
   localparam int FP_HMVIP_MCYC = (FP_HMVIP_NS * MCLK_KHZ + 999999) / 1000000;
   // local frame pulse output width
   localparam int FPO_NS = 244;
   localparam int FPO_MCYC = (FPO_NS * MCLK_KHZ + 999999) / 1000000;
   localparam logic [CNT_W-1:0] FPO_LOW_START = CNT_W'(FRAME_MCYC - FPO_MCYC / 2);
   localparam logic [CNT_W-1:0] FPO_LOW_END = CNT_W'(FPO_MCYC / 2 - 1);
   // local clock bit of the frame counter (master / 4)
   localparam int LCLK_BIT = 1;
   // width counter saturation
   localparam int FPW_W = 4;
   // stream lanes: backplane 0..31, then local 0..12
   localparam int N_BP = 32;
   localparam int N_LOC = 13;
   localparam int N_LANE = N_BP + N_LOC;
   localparam int N_EVAL = 24;
   localparam int BP_MID_FIRST = 16;
   localparam int BP_HI_FIRST = 24;
   localparam int LOC_SLOW_FIRST = 4;
   localparam int LOC_SUB_IDX = 12;
   localparam int SUB_BITS = 2;
   // frame alignment modes
   typedef enum logic [1:0] {
      ALIGN_NATIVE = 2'b00,
      ALIGN_CT = 2'b01,
      ALIGN_HMVIP = 2'b10
   } tsr_align_t;
   // backplane modes
   typedef enum logic [1:0] {
      BP_2M = 2'b00,
      BP_4M = 2'b01,
      BP_8M = 2'b10,
      BP_HMVIP = 2'b11
   } tsr_bp_mode_t;
   // local modes
   typedef enum logic [1:0] {
      LOC_2M = 2'b00,
      LOC_8M = 2'b01,
      LOC_SUB = 2'b10
   } tsr_loc_mode_t;
   // per-lane rate
   typedef enum logic [2:0] {
      RATE_OFF = 3'b000,
      RATE_2M = 3'b001,
      RATE_4M = 3'b010,
      RATE_8M = 3'b011,
      RATE_SUB = 3'b100
   } tsr_rate_t;
endpackage

// ### rtl/tsr_timing_if.sv
// frame timing carried from the timing generator to the stream lanes
`timescale 1ns/100ps
interface tsr_timing_if import tsr_pkg::*; ();
   logic tick; // one ref cycle per master clock rising edge
   logic [CNT_W-1:0] frame_cnt; // master cycle within frame
   modport src (output tick, output frame_cnt);
   modport dst (input tick, input frame_cnt);
endinterface

// ### rtl/tsr_frame_timing.sv
// frame counter, frame pulse alignment and local clock/frame outputs
`timescale 1ns/100ps
module tsr_frame_timing import tsr_pkg::*; (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic master_clk_in,
   input wire logic master_frame_pulse_n_in,
   input wire logic bus_align_clk_in,
   input wire logic [1:0] align_mode_in,
   tsr_timing_if.src tim,
   output logic local_clk_out,
   output logic local_frame_pulse_n_out,
   output logic fp_width_err_out
);
   logic mclk_reg; // previous master clock level
   logic aclk_reg; // previous bus clock level
   logic fp_reg; // frame pulse level at last master tick
   logic align_pend_reg; // bus-clock aligned frame start waiting for a tick
   logic [CNT_W-1:0] cnt_reg; // master cycle within frame
   logic [FPW_W-1:0] fpw_reg; // low width of current frame pulse
   logic tick;
   logic aclk_rise;
   logic native_start;
   logic [FPW_W-1:0] fpw_expect;

   assign tick = master_clk_in & ~mclk_reg;
   assign aclk_rise = bus_align_clk_in & ~aclk_reg;
   assign native_start = tick & fp_reg & ~master_frame_pulse_n_in;
   assign tim.tick = tick;
   assign tim.frame_cnt = cnt_reg;

   // expected low width in master cycles for the selected framing
   always_comb begin
      unique case (align_mode_in)
         ALIGN_CT: fpw_expect = FPW_W'(FP_CT_MCYC);
         ALIGN_HMVIP: fpw_expect = FPW_W'(FP_HMVIP_MCYC);
         default: fpw_expect = FPW_W'(FP_NATIVE_MCYC); // native, and illegal code
      endcase
   end

   // edge history of the two clock inputs
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mclk_reg <= 1'b0;
         aclk_reg <= 1'b0;
      end else begin
         mclk_reg <= master_clk_in;
         aclk_reg <= bus_align_clk_in;
      end
   end

   // in CT and HMVIP framing the bus clock edge marks the frame start
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         align_pend_reg <= 1'b0;
      end else if (align_mode_in != ALIGN_NATIVE && aclk_rise && !master_frame_pulse_n_in && fp_reg) begin
         align_pend_reg <= 1'b1;
      end else if (tick) begin
         align_pend_reg <= 1'b0;
      end
   end

   // frame counter; restarts on the aligned frame edge, else wraps each 125 us
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg <= '0;
      end else if (tick) begin
         if ((align_mode_in == ALIGN_NATIVE) ? native_start : align_pend_reg) begin
            cnt_reg <= '0;
         end else if (cnt_reg == CNT_LAST) begin
            cnt_reg <= '0;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   // frame pulse width check; flags a pulse whose low time misses the mode width
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fp_reg <= 1'b1;
         fpw_reg <= '0;
         fp_width_err_out <= 1'b0;
      end else begin
         fp_width_err_out <= 1'b0;
         if (tick) begin
            fp_reg <= master_frame_pulse_n_in;
            if (!master_frame_pulse_n_in) begin
               if (fpw_reg != '1) begin
                  fpw_reg <= fpw_reg + 1'b1; // saturates, so long lows still report
               end
            end else begin
               fpw_reg <= '0;
               if (!fp_reg && fpw_reg != fpw_expect) begin
                  fp_width_err_out <= 1'b1;
               end
            end
         end
      end
   end

   // local 4.096 MHz clock and 244 ns frame pulse straddling the boundary
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         local_clk_out <= 1'b0;
         local_frame_pulse_n_out <= 1'b1;
      end else begin
         local_clk_out <= ~cnt_reg[LCLK_BIT];
         local_frame_pulse_n_out <= ~(cnt_reg >= FPO_LOW_START || cnt_reg <= FPO_LOW_END);
      end
   end
endmodule

// ### rtl/tsr_stream_top.sv
// serial stream lanes of the rate converting switch with their frame timing
`timescale 1ns/100ps
module tsr_stream_top import tsr_pkg::*; (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic master_clk_in,
   input wire logic master_frame_pulse_n_in,
   input wire logic bus_align_clk_in,
   input wire logic [1:0] align_mode_in,
   input wire logic [1:0] bp_mode_in,
   input wire logic [1:0] local_mode_in,
   input wire logic frame_eval_mode_in,
   input wire logic output_drive_gate_in,
   input wire logic [15:0] bp_stream_lo_in,
   output logic [15:0] bp_stream_lo_out,
   output logic [15:0] bp_stream_lo_oe_out,
   input wire logic [7:0] bp_stream_mid_in,
   output logic [7:0] bp_stream_mid_out,
   output logic [7:0] bp_stream_mid_oe_out,
   input wire logic [7:0] bp_stream_hi_in,
   output logic [7:0] bp_stream_hi_out,
   output logic [7:0] bp_stream_hi_oe_out,
   input wire logic [3:0] local_in_fast_in,
   input wire logic [7:0] local_in_slow_in,
   input wire logic local_in_sub_in,
   output logic [12:0] local_stream_out,
   output logic [12:0] local_stream_oe_out,
   input wire logic [31:0] bp_drive_in,
   input wire logic [N_LANE-1:0][7:0] tx_data_in,
   output logic [N_LANE-1:0] tx_load_out,
   output logic [N_LANE-1:0][7:0] rx_data_out,
   output logic [N_LANE-1:0] rx_valid_out,
   output logic [N_LANE-1:0] lane_active_out,
   output logic [N_EVAL-1:0] frame_eval_out,
   output logic [CNT_W-1:0] frame_count_out,
   output logic local_clk_out,
   output logic local_frame_pulse_n_out,
   output logic fp_width_err_out
);
   logic rst_meta_reg; // first reset release stage
   logic rst_sync_reg; // released reset used everywhere else
   logic [N_LANE-1:0] lane_in; // serial input level per lane
   logic [N_LANE-1:0] lane_out_reg; // serial output bit per lane
   logic [N_LANE-1:0] lane_drive; // lane output enable before the gate
   logic [N_LANE-1:0] lane_rx_ok; // lane may receive this frame
   tsr_bp_mode_t bp_mode;
   tsr_loc_mode_t loc_mode;

   tsr_timing_if tim ();

   assign bp_mode = tsr_bp_mode_t'(bp_mode_in);
   assign loc_mode = tsr_loc_mode_t'(local_mode_in);

   // rate of a lane for the selected backplane and local modes
   function automatic tsr_rate_t lane_rate(input int idx, input tsr_bp_mode_t bpm, input tsr_loc_mode_t lm);
      tsr_rate_t r;
      r = RATE_OFF;
      if (idx < BP_MID_FIRST) begin
         unique case (bpm)
            BP_2M: r = RATE_2M;
            BP_4M: r = RATE_4M;
            BP_8M: r = RATE_8M;
            BP_HMVIP: r = RATE_2M;
         endcase
      end else if (idx < BP_HI_FIRST) begin
         unique case (bpm)
            BP_2M: r = RATE_2M;
            BP_4M: r = RATE_4M;
            BP_8M: r = RATE_OFF;
            BP_HMVIP: r = RATE_8M;
         endcase
      end else if (idx < N_BP) begin
         r = (bpm == BP_2M) ? RATE_2M : (bpm == BP_4M) ? RATE_4M : RATE_OFF;
      end else if (idx < N_BP + LOC_SLOW_FIRST) begin
         r = (lm == LOC_8M) ? RATE_8M : (lm == LOC_2M || lm == LOC_SUB) ? RATE_2M : RATE_OFF;
      end else if (idx < N_BP + LOC_SUB_IDX) begin
         r = (lm == LOC_2M || lm == LOC_SUB) ? RATE_2M : RATE_OFF;
      end else begin
         r = (lm == LOC_2M) ? RATE_2M : (lm == LOC_SUB) ? RATE_SUB : RATE_OFF;
      end
      return r;
   endfunction

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // frame timing generator
   tsr_frame_timing u_timing (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_sync_reg),
      .master_clk_in(master_clk_in),
      .master_frame_pulse_n_in(master_frame_pulse_n_in),
      .bus_align_clk_in(bus_align_clk_in),
      .align_mode_in(align_mode_in),
      .tim(tim.src),
      .local_clk_out(local_clk_out),
      .local_frame_pulse_n_out(local_frame_pulse_n_out),
      .fp_width_err_out(fp_width_err_out)
   );

   assign frame_count_out = tim.frame_cnt;

   // gather all serial inputs into one lane vector
   assign lane_in = {local_in_sub_in, local_in_slow_in, local_in_fast_in,
                     bp_stream_hi_in, bp_stream_mid_in, bp_stream_lo_in};

   // a backplane lane drives when its direction bit says so, local lanes always drive
   assign lane_drive = {{N_LOC{1'b1}}, bp_drive_in};

   // gated drivers; eval mode turns the first backplane pins into pure inputs
   always_comb begin
      logic [N_LANE-1:0] en;
      en = '0;
      for (int k = 0; k < N_LANE; k++) begin
         en[k] = output_drive_gate_in & lane_active_out[k] & lane_drive[k];
         if (frame_eval_mode_in && k < N_EVAL) begin
            en[k] = 1'b0;
         end
      end
      bp_stream_lo_oe_out = en[15:0];
      bp_stream_mid_oe_out = en[23:16];
      bp_stream_hi_oe_out = en[31:24];
      local_stream_oe_out = en[N_LANE-1:N_BP];
   end

   // output data levels come straight from the lane bit flops
   assign bp_stream_lo_out = lane_out_reg[15:0];
   assign bp_stream_mid_out = lane_out_reg[23:16];
   assign bp_stream_hi_out = lane_out_reg[31:24];
   assign local_stream_out = lane_out_reg[N_LANE-1:N_BP];

   // backplane lanes receive unless they drive, local lanes always do; none while serving frame evaluation
   always_comb begin
      for (int k = 0; k < N_LANE; k++) begin
         lane_rx_ok[k] = ~lane_drive[k] | (k >= N_BP);
         if (frame_eval_mode_in && k < N_EVAL) begin
            lane_rx_ok[k] = 1'b0;
         end
      end
   end

   // evaluation inputs sampled at each frame boundary while eval mode is on
   always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         frame_eval_out <= '0;
      end else if (!frame_eval_mode_in) begin
         frame_eval_out <= '0;
      end else if (tim.tick && tim.frame_cnt == '0) begin
         frame_eval_out <= lane_in[N_EVAL-1:0];
      end
   end

   // one lane per stream; bit timing taken from the frame counter
   for (genvar i = 0; i < N_LANE; i++) begin : g_lane
      tsr_rate_t rate;
      logic bit_start; // first master cycle of a bit
      logic bit_end; // last master cycle of a bit, where input is sampled
      logic [2:0] pos; // bit position within channel
      logic [2:0] last_pos; // final bit position of a channel
      logic [7:0] rx_shift_reg; // bits received so far this channel
      logic [7:0] tx_hold_reg; // channel byte being sent
      logic [7:0] rx_full;

      assign rate = lane_rate(i, bp_mode, loc_mode);
      assign lane_active_out[i] = (rate != RATE_OFF);
      assign rx_full = {rx_shift_reg[6:0], lane_in[i]};

      // bit slots: 8.192 Mb/s is 2 master cycles, 4.096 is 4, 2.048 is 8
      always_comb begin
         bit_start = 1'b0;
         bit_end = 1'b0;
         pos = 3'h0;
         last_pos = 3'h7;
         unique case (rate)
            RATE_8M: begin
               bit_start = (tim.frame_cnt[0] == 1'b0);
               bit_end = (tim.frame_cnt[0] == 1'b1);
               pos = tim.frame_cnt[3:1]; // 128 channels per frame
            end
            RATE_4M: begin
               bit_start = (tim.frame_cnt[1:0] == 2'h0);
               bit_end = (tim.frame_cnt[1:0] == 2'h3);
               pos = tim.frame_cnt[4:2]; // 64 channels per frame
            end
            RATE_2M: begin
               bit_start = (tim.frame_cnt[2:0] == 3'h0);
               bit_end = (tim.frame_cnt[2:0] == 3'h7);
               pos = tim.frame_cnt[5:3]; // 32 channels per frame
            end
            RATE_SUB: begin
               bit_start = (tim.frame_cnt[2:0] == 3'h0);
               bit_end = (tim.frame_cnt[2:0] == 3'h7);
               pos = {2'h0, tim.frame_cnt[3]};
               last_pos = 3'(SUB_BITS - 1);
            end
            RATE_OFF: begin
               bit_start = 1'b0; // idle lane never shifts
            end
            default: begin
               bit_start = 1'b0; // unused rate codes stay idle
            end
         endcase
      end

      // receive: shift in at bit end, hand over the channel at its last bit
      always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
         if (!rst_sync_reg) begin
            rx_shift_reg <= '0;
            rx_data_out[i] <= '0;
            rx_valid_out[i] <= 1'b0;
         end else begin
            rx_valid_out[i] <= 1'b0;
            if (tim.tick && bit_end && lane_rx_ok[i]) begin
               rx_shift_reg <= rx_full;
               if (pos == last_pos) begin
                  // sub-rate channels carry two bits, kept in the low end
                  rx_data_out[i] <= (rate == RATE_SUB) ? {6'h00, rx_full[1:0]} : rx_full;
                  rx_valid_out[i] <= 1'b1;
               end
            end
         end
      end

      // transmit: take the channel byte at its first bit, msb first
      always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
         if (!rst_sync_reg) begin
            tx_hold_reg <= '0;
            lane_out_reg[i] <= 1'b0;
            tx_load_out[i] <= 1'b0;
         end else begin
            tx_load_out[i] <= 1'b0;
            if (rate == RATE_OFF) begin
               lane_out_reg[i] <= 1'b0; // idle lanes rest low
            end else if (tim.tick && bit_start) begin
               if (pos == 3'h0) begin
                  tx_hold_reg <= tx_data_in[i];
                  lane_out_reg[i] <= tx_data_in[i][last_pos];
                  tx_load_out[i] <= 1'b1;
               end else begin
                  lane_out_reg[i] <= tx_hold_reg[last_pos - pos];
               end
            end
         end
      end
   end
endmodule

// ### tb/tsr_stream_assertions.sv
// concurrent checks on the top-level ports of the stream block
`timescale 1ns/100ps
module tsr_stream_checker import tsr_pkg::*; (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic master_frame_pulse_n_in,
   input wire logic [1:0] align_mode_in,
   input wire logic [1:0] bp_mode_in,
   input wire logic [1:0] local_mode_in,
   input wire logic frame_eval_mode_in,
   input wire logic output_drive_gate_in,
   input wire logic [15:0] bp_stream_lo_oe_out,
   input wire logic [7:0] bp_stream_mid_oe_out,
   input wire logic [7:0] bp_stream_hi_oe_out,
   input wire logic [12:0] local_stream_oe_out,
   input wire logic [N_LANE-1:0] rx_valid_out,
   input wire logic [N_LANE-1:0] lane_active_out,
   input wire logic [CNT_W-1:0] frame_count_out,
   input wire logic local_clk_out,
   input wire logic local_frame_pulse_n_out,
   input wire logic fp_width_err_out
);
   logic [3:0] live_reg; // release history
   logic lclk_bit; // counter bit that the local clock follows
   assign lclk_bit = frame_count_out[LCLK_BIT];
   // keeps $past away from the reset-held outputs
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         live_reg <= 4'h0;
      end else begin
         live_reg <= {live_reg[2:0], 1'b1};
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // native frame start and the counter restart it causes
   sequence s_native_fall;
      live_reg[3] && align_mode_in == ALIGN_NATIVE && $fell(master_frame_pulse_n_in);
   endsequence
   sequence s_count_zero;
      frame_count_out == 11'h000;
   endsequence
   a_native_realign: assert property (s_native_fall |-> ##[1:6] s_count_zero)
      else $error("no realign");
   a_count_step: assert property ($changed(frame_count_out) |-> frame_count_out == 11'h000 ||
      frame_count_out == $past(frame_count_out) + 1'b1) else $error("frame count skipped");
   a_lclk_phase: assert property (live_reg[3] |-> local_clk_out == ~$past(lclk_bit))
      else $error("local clock phase");
   a_lfp_window: assert property (live_reg[3] |-> local_frame_pulse_n_out ==
      !($past(frame_count_out) >= FPO_LOW_START || $past(frame_count_out) <= FPO_LOW_END))
      else $error("local frame window");
   a_gate_off: assert property (!output_drive_gate_in |-> local_stream_oe_out == 13'h0000 &&
      bp_stream_lo_oe_out == 16'h0000 && bp_stream_mid_oe_out == 8'h00 && bp_stream_hi_oe_out == 8'h00)
      else $error("stream driven while gate low");
   a_eval_quiet: assert property (frame_eval_mode_in |-> bp_stream_lo_oe_out == 16'h0000 &&
      bp_stream_mid_oe_out == 8'h00) else $error("evaluation pin driven");
   a_hi_unused: assert property (bp_mode_in == BP_8M || bp_mode_in == BP_HMVIP |->
      lane_active_out[31:24] == 8'h00 && bp_stream_hi_oe_out == 8'h00) else $error("upper lanes active");
   a_mid_8m: assert property (bp_mode_in == BP_8M |-> lane_active_out[23:0] == 24'h00ffff)
      else $error("8M lanes");
   a_rx_fast8: assert property (rx_valid_out[32] && local_mode_in == LOC_8M &&
      $past(local_mode_in, 40) == LOC_8M |-> frame_count_out[3:0] == 4'h0) else $error("fast lane rate");
   a_rx_slow2: assert property (rx_valid_out[36] && local_mode_in == LOC_2M &&
      $past(local_mode_in, 150) == LOC_2M |-> frame_count_out[5:0] == 6'h00) else $error("slow lane rate");
   a_rx_sub: assert property (rx_valid_out[44] && local_mode_in == LOC_SUB &&
      $past(local_mode_in, 40) == LOC_SUB |-> frame_count_out[3:0] == 4'h0) else $error("sub-rate lane rate");
   a_err_pulse: assert property (fp_width_err_out |-> master_frame_pulse_n_in ##1 !fp_width_err_out)
      else $error("width error pulse");
   a_reset_clear: assert property (disable iff (1'b0) !rst_n_in && $past(!rst_n_in) |->
      frame_count_out == 11'h000 && local_frame_pulse_n_out && rx_valid_out == '0)
      else $error("outputs not cleared in reset");
endmodule
bind tsr_stream_top tsr_stream_checker tsr_stream_checker_i (.*);

// ### tb/tsr_tdm_peer.sv
// far-end timing source and local stream loopback for the stream block
`timescale 1ns/100ps
module tsr_tdm_peer import tsr_pkg::*; (
   input wire logic ref_clk_in,
   input wire logic run_in,
   input wire logic hmvip_in,
   input wire logic [3:0] fp_ticks_in,
   input wire logic [12:0] loc_data_in,
   input wire logic [12:0] loc_oe_in,
   output logic master_clk_out,
   output logic frame_pulse_n_out,
   output logic bus_clk_out,
   output logic [12:0] loc_data_out
);
   logic [CNT_W-1:0] pos_reg = 11'h000; // master cycle within the far-end frame
   logic [12:0] last_reg = 13'h0000; // last driven level per line
   initial begin
      master_clk_out = 1'b0;
      frame_pulse_n_out = 1'b1;
      bus_clk_out = 1'b0;
   end
   // master clock at half the ref rate; bus clock rises with the frame pulse fall
   always @(posedge ref_clk_in) begin
      #1;
      if (!run_in) begin
         master_clk_out = 1'b0;
         pos_reg = 11'h000;
      end else begin
         master_clk_out = ~master_clk_out;
         if (master_clk_out) begin
            pos_reg = (pos_reg == CNT_LAST) ? 11'h000 : pos_reg + 1'b1;
            frame_pulse_n_out = !(pos_reg < CNT_W'(fp_ticks_in));
            bus_clk_out = hmvip_in ? ~pos_reg[1] : ~pos_reg[0];
         end
      end
   end
   // released lines show the inverse of their last level
   always @(posedge ref_clk_in) begin
      last_reg <= (loc_oe_in & loc_data_in) | (~loc_oe_in & last_reg);
   end
   assign loc_data_out = (loc_oe_in & loc_data_in) | (~loc_oe_in & ~last_reg);
endmodule

// ### tb/tb_top.sv
// self-checking bench for the stream block
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top import tsr_pkg::*; ();
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic run = 1'b0;
   logic hmvip = 1'b0;
   logic [3:0] fp_ticks = 4'h1;
   logic [1:0] align_mode = 2'h0;
   logic [1:0] bp_mode = 2'h0;
   logic [1:0] local_mode = 2'h3; // local lanes off
   logic eval_mode = 1'b0;
   logic gate = 1'b0;
   logic [15:0] bp_lo = 16'h0000;
   logic [7:0] bp_mid = 8'h00;
   logic [7:0] bp_hi = 8'h00;
   logic [31:0] bp_drive = 32'h00000000;
   logic [N_LANE-1:0][7:0] tx_data = '0;
   logic master_clk, fp_n, bus_clk;
   logic [12:0] loc_out, loc_oe, loc_back;
   logic [15:0] bp_stream_lo_oe_out;
   logic [7:0] bp_stream_mid_oe_out, bp_stream_hi_oe_out;
   logic [N_LANE-1:0][7:0] rx_data_out;
   logic [N_LANE-1:0] rx_valid_out, lane_active_out;
   logic [N_EVAL-1:0] frame_eval_out;
   logic [CNT_W-1:0] frame_count_out;
   logic local_clk_out, local_frame_pulse_n_out, fp_width_err_out;
   int miscompares = 0;
   int comparisons = 0;
   int err_seen = 0; // width error pulses
   always #25 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) if (fp_width_err_out === 1'b1) err_seen++;
   tsr_tdm_peer tsr_tdm_peer_i (.ref_clk_in(ref_clk_in), .run_in(run), .hmvip_in(hmvip), .fp_ticks_in(fp_ticks),
      .loc_data_in(loc_out), .loc_oe_in(loc_oe), .master_clk_out(master_clk), .frame_pulse_n_out(fp_n),
      .bus_clk_out(bus_clk), .loc_data_out(loc_back));
   tsr_stream_top tsr_stream_top_i (.*, .master_clk_in(master_clk), .master_frame_pulse_n_in(fp_n),
      .bus_align_clk_in(bus_clk), .align_mode_in(align_mode), .bp_mode_in(bp_mode), .local_mode_in(local_mode),
      .frame_eval_mode_in(eval_mode), .output_drive_gate_in(gate), .bp_stream_lo_in(bp_lo), .bp_stream_lo_out(),
      .bp_stream_mid_in(bp_mid), .bp_stream_mid_out(), .bp_stream_hi_in(bp_hi), .bp_stream_hi_out(),
      .local_in_fast_in(loc_back[3:0]), .local_in_slow_in(loc_back[11:4]), .local_in_sub_in(loc_back[12]),
      .local_stream_out(loc_out), .local_stream_oe_out(loc_oe), .bp_drive_in(bp_drive), .tx_data_in(tx_data),
      .tx_load_out());
   // inputs always move just after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic stop_test();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // one framing mode and pulse width
   task automatic t_align(input logic [1:0] mode, input logic [3:0] w, input logic exp_err);
      int n;
      align_mode = mode;
      hmvip = (mode == ALIGN_HMVIP);
      fp_ticks = w;
      step(4200);
      err_seen = 0;
      n = 0;
      while (local_frame_pulse_n_out !== 1'b1 && n < 5000) begin step(1); n++; end
      while (local_frame_pulse_n_out !== 1'b0 && n < 5000) begin step(1); n++; end
      `CHK(n < 5000, 1'b1)
      n = 0;
      while (local_frame_pulse_n_out === 1'b0 && n < 50) begin step(1); n++; end
      `CHK(n, 8)
      while (local_frame_pulse_n_out === 1'b1 && n < 5000) begin step(1); n++; end
      `CHK(n, 4096)
      `CHK(err_seen != 0, exp_err)
      n = 0;
      while (local_clk_out !== 1'b1 && n < 20) begin step(1); n++; end
      while (local_clk_out !== 1'b0 && n < 20) begin step(1); n++; end
      n = 0;
      while (local_clk_out === 1'b0 && n < 20) begin step(1); n++; end
      `CHK(n, 4)
   endtask
   // lanes active in each mode
   task automatic t_lanes();
      logic [31:0] exp_bp [4] = '{32'hffffffff, 32'hffffffff, 32'h0000ffff, 32'h00ffffff};
      logic [12:0] exp_loc [4] = '{13'h1fff, 13'h000f, 13'h1fff, 13'h0000};
      for (int i = 0; i < 4; i++) begin
         bp_mode = 2'(i);
         local_mode = 2'(i);
         step(1);
         `CHK(lane_active_out[31:0], exp_bp[i])
         `CHK(lane_active_out[44:32], exp_loc[i])
      end
      bp_mode = BP_2M;
      local_mode = 2'h3;
   endtask
   // drive gate, evaluation mode and its snapshot
   task automatic t_gate();
      bp_drive = 32'hffffffff;
      step(1);
      `CHK(bp_stream_lo_oe_out, 16'h0000)
      gate = 1'b1;
      step(1);
      `CHK(bp_stream_hi_oe_out, 8'hff)
      eval_mode = 1'b1;
      bp_lo = 16'h5a3c;
      bp_mid = 8'hc3;
      step(1);
      `CHK(bp_stream_mid_oe_out, 8'h00)
      `CHK(bp_stream_hi_oe_out, 8'hff)
      step(4200);
      `CHK(frame_eval_out, 24'hc35a3c)
      eval_mode = 1'b0;
      bp_drive = 32'h00000000;
      step(2);
      `CHK(frame_eval_out, 24'h000000)
   endtask
   // looped-back local lane: third received channel holds what the mode carries
   task automatic t_loop(input logic [1:0] mode, input int ln, input logic [7:0] val, input logic [7:0] exp);
      int n;
      int got;
      local_mode = mode;
      tx_data[ln] = val;
      n = 0;
      got = 0;
      while (got < 3 && n < 1000) begin
         step(1);
         n++;
         if (rx_valid_out[ln] === 1'b1) got++;
      end
      `CHK(rx_data_out[ln], exp)
   endtask
   initial begin
      step(4);
      `CHK(frame_count_out, 11'h000)
      `CHK(local_frame_pulse_n_out, 1'b1)
      step(4);
      rst_n_in = 1'b1;
      step(3);
      run = 1'b1;
      t_align(ALIGN_NATIVE, 4'h1, 1'b0);
      t_lanes();
      t_gate();
      t_loop(LOC_2M, 32, 8'ha5, 8'ha5);
      t_loop(LOC_8M, 32, 8'h3c, 8'h3c);
      t_loop(LOC_SUB, 32, 8'h96, 8'h96);
      t_loop(LOC_SUB, 44, 8'h96, 8'h02);
      local_mode = 2'h3;
      t_align(ALIGN_NATIVE, 4'h3, 1'b1);
      t_align(ALIGN_CT, 4'h2, 1'b0);
      t_align(ALIGN_HMVIP, 4'h4, 1'b0);
      stop_test();
   end
   // about 80k cycles, well beyond the expected run
   initial begin
      #4000000;
      miscompares++;
      stop_test();
   end
endmodule
